// ---- hpgio_pkg.sv ----
// Function
// - Host data pins serve as GPIO only when port disabled or wide mode set.
// - GPIO exists on 8 host data pins and 16 serial pins when free.
// - Direction bits 7..0: 0 makes the pin an input, 1 an output.
// - Control bit 15 gates the timer-1 output onto the shared pin.
// - Timer-1 reaches the shared pin only while the host port is disabled.
// - Reading the pin-level register returns the host data pin levels.
// - Writing the pin-level register sets levels of output-direction pins.
// - Serial pins act as GPIO only while their owning section is in reset.
package hpgio_pkg;

  localparam int          HPGIO_ADDR_W      = 16;
  localparam int          HPGIO_DATA_W      = 16;
  localparam int          HPGIO_HD_PINS     = 8;
  localparam int          HPGIO_SER_PINS    = 16;

  localparam logic [15:0] HPGIO_DIR_CTRL_OFS = 16'h003C;
  localparam logic [15:0] HPGIO_LEVEL_OFS    = 16'h003D;

  localparam int          HPGIO_TOUT_EN_BIT  = 15;
  localparam int          HPGIO_DIR_LSB      = 0;
  localparam int          HPGIO_LVL_LSB      = 0;

  localparam logic [7:0]  HPGIO_DIR_RST      = 8'h00;
  localparam logic [7:0]  HPGIO_LVL_RST      = 8'h00;
  localparam logic        HPGIO_TOUT_RST     = 1'h0;
  localparam logic [15:0] HPGIO_RDATA_RST    = 16'h0000;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [15:0] wdata;
  } hpgio_mmr_req_s;

  typedef struct packed {
    logic [7:0] dir;
    logic [7:0] lvl;
    logic       tout_en;
  } hpgio_regs_s;

endpackage

// ---- hpgio_pin_mux.sv ----
`timescale 1ns/100ps
`default_nettype none
module hpgio_pin_mux #(
  parameter int W = 8
) (
  input  wire logic         sys_clk_in,
  input  wire logic         reset_n_in,
  input  wire logic [W-1:0] gpio_sel_in,
  input  wire logic [W-1:0] prim_out_in,
  input  wire logic [W-1:0] prim_oe_in,
  input  wire logic [W-1:0] gpio_out_in,
  input  wire logic [W-1:0] gpio_oe_in,
  output logic      [W-1:0] pin_out_out,
  output logic      [W-1:0] pin_oe_out
);

  logic [W-1:0] out_d;
  logic [W-1:0] oe_d;
  logic [W-1:0] out_q;
  logic [W-1:0] oe_q;

  // Registered pad drive keeps ownership switches glitch free
  for (genvar i = 0; i < W; i++) begin : g_pin
    always_comb begin
      out_d[i] = gpio_sel_in[i] ? gpio_out_in[i] : prim_out_in[i];
      oe_d[i]  = gpio_sel_in[i] ? gpio_oe_in[i]  : prim_oe_in[i];
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      out_q <= '0;
      oe_q  <= '0;
    end else begin
      out_q <= out_d;
      oe_q  <= oe_d;
    end
  end

  assign pin_out_out = out_q;
  assign pin_oe_out  = oe_q;

endmodule // hpgio_pin_mux
`default_nettype wire

// ---- hpgio_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module hpgio_top (
  input  wire logic                      sys_clk_in,
  input  wire logic                      reset_n_in,
  input  wire hpgio_pkg::hpgio_mmr_req_s mmr_req_in,
  output logic                    [15:0] mmr_rdata_out,
  input  wire logic                      host_port_enable_input_in,
  input  wire logic                      host_port_wide_mode_in,
  input  wire logic                [7:0] host_data_pins_in,
  output logic                     [7:0] host_data_pins_out,
  output logic                     [7:0] host_data_pins_oe_out,
  input  wire logic                [7:0] hpi_data_out_in,
  input  wire logic                [7:0] hpi_data_oe_in,
  input  wire logic                      host_irq_n_in,
  input  wire logic                      timer_one_out_in,
  output logic                           shared_host_irq_timer_pin_out,
  output logic                           shared_host_irq_timer_pin_oe_out,
  input  wire logic               [15:0] ser_section_reset_in,
  input  wire logic               [15:0] ser_prim_out_in,
  input  wire logic               [15:0] ser_prim_oe_in,
  input  wire logic               [15:0] ser_gpio_out_in,
  input  wire logic               [15:0] ser_gpio_oe_in,
  output logic                    [15:0] ser_pins_out,
  output logic                    [15:0] ser_pins_oe_out
);

  hpgio_pkg::hpgio_regs_s regs_d;
  hpgio_pkg::hpgio_regs_s regs_q;
  logic [15:0]            rdata_d;
  logic [15:0]            rdata_q;
  logic                   shp_out_d;
  logic                   shp_oe_d;
  logic                   shp_out_q;
  logic                   shp_oe_q;
  logic                   hd_gpio_ok;
  logic                   sel_cr;
  logic                   sel_sr;
  logic [7:0]             hd_sel;

  assign sel_cr     = mmr_req_in.addr == hpgio_pkg::HPGIO_DIR_CTRL_OFS;
  assign sel_sr     = mmr_req_in.addr == hpgio_pkg::HPGIO_LEVEL_OFS;
  assign hd_gpio_ok = !host_port_enable_input_in || host_port_wide_mode_in;
  assign hd_sel     = {8{hd_gpio_ok}};

  always_comb begin
    regs_d  = regs_q;
    rdata_d = rdata_q;
    if (mmr_req_in.wr && sel_cr) begin
      regs_d.dir     = mmr_req_in.wdata[hpgio_pkg::HPGIO_DIR_LSB +: 8];
      regs_d.tout_en = mmr_req_in.wdata[hpgio_pkg::HPGIO_TOUT_EN_BIT];
    end
    if (mmr_req_in.wr && sel_sr) begin
      regs_d.lvl = mmr_req_in.wdata[hpgio_pkg::HPGIO_LVL_LSB +: 8];
    end
    if (mmr_req_in.rd) begin
      // Reserved bits and unmapped reads give zero
      rdata_d = hpgio_pkg::HPGIO_RDATA_RST;
      if (sel_cr) begin
        rdata_d[hpgio_pkg::HPGIO_DIR_LSB +: 8]     = regs_q.dir;
        rdata_d[hpgio_pkg::HPGIO_TOUT_EN_BIT]      = regs_q.tout_en;
      end else if (sel_sr) begin
        // Pin level, not latch: output pins read back via the pad
        rdata_d[hpgio_pkg::HPGIO_LVL_LSB +: 8] = host_data_pins_in;
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      regs_q.dir     <= hpgio_pkg::HPGIO_DIR_RST;
      regs_q.lvl     <= hpgio_pkg::HPGIO_LVL_RST;
      regs_q.tout_en <= hpgio_pkg::HPGIO_TOUT_RST;
      rdata_q        <= hpgio_pkg::HPGIO_RDATA_RST;
    end else begin
      regs_q  <= regs_d;
      rdata_q <= rdata_d;
    end
  end

  assign mmr_rdata_out = rdata_q;

  // Shared pin: port enabled keeps its interrupt; disabled lets timer through
  always_comb begin
    if (host_port_enable_input_in) begin
      shp_out_d = host_irq_n_in;
      shp_oe_d  = 1'h1;
    end else begin
      shp_out_d = timer_one_out_in;
      shp_oe_d  = regs_q.tout_en;
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      shp_out_q <= 1'h0;
      shp_oe_q  <= 1'h0;
    end else begin
      shp_out_q <= shp_out_d;
      shp_oe_q  <= shp_oe_d;
    end
  end

  assign shared_host_irq_timer_pin_out    = shp_out_q;
  assign shared_host_irq_timer_pin_oe_out = shp_oe_q;

  hpgio_pin_mux #(
    .W (hpgio_pkg::HPGIO_HD_PINS)
  ) u_hd_mux (
    .sys_clk_in  (sys_clk_in),
    .reset_n_in  (reset_n_in),
    .gpio_sel_in (hd_sel),
    .prim_out_in (hpi_data_out_in),
    .prim_oe_in  (hpi_data_oe_in),
    .gpio_out_in (regs_q.lvl),
    .gpio_oe_in  (regs_q.dir),
    .pin_out_out (host_data_pins_out),
    .pin_oe_out  (host_data_pins_oe_out)
  );

  hpgio_pin_mux #(
    .W (hpgio_pkg::HPGIO_SER_PINS)
  ) u_ser_mux (
    .sys_clk_in  (sys_clk_in),
    .reset_n_in  (reset_n_in),
    .gpio_sel_in (ser_section_reset_in),
    .prim_out_in (ser_prim_out_in),
    .prim_oe_in  (ser_prim_oe_in),
    .gpio_out_in (ser_gpio_out_in),
    .gpio_oe_in  (ser_gpio_oe_in),
    .pin_out_out (ser_pins_out),
    .pin_oe_out  (ser_pins_oe_out)
  );

  logic [7:0] wlo;
  assign wlo = mmr_req_in.wdata[7:0];

  sequence s_wr_lvl;
    mmr_req_in.wr && sel_sr;
  endsequence

  sequence s_rd_cr;
    mmr_req_in.rd && sel_cr;
  endsequence

  sequence s_rd_sr;
    mmr_req_in.rd && sel_sr;
  endsequence

  sequence s_wr_cr;
    mmr_req_in.wr && sel_cr;
  endsequence

  sequence s_rd_none;
    mmr_req_in.rd && !sel_cr && !sel_sr;
  endsequence

  AST_HD_PRIMARY: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    !hd_gpio_ok |=> host_data_pins_oe_out == $past(hpi_data_oe_in))
    else $error("host pins not handed to host port");

  AST_HD_DIR: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    hd_gpio_ok |=> host_data_pins_oe_out == $past(regs_q.dir))
    else $error("pin enables do not follow direction bits");

  AST_TOUT_OFF: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    (!host_port_enable_input_in && !regs_q.tout_en) |=> !shared_host_irq_timer_pin_oe_out)
    else $error("timer driven while its enable is off");

  AST_TOUT_ON: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    (!host_port_enable_input_in && regs_q.tout_en) |=>
      shared_host_irq_timer_pin_oe_out &&
      shared_host_irq_timer_pin_out == $past(timer_one_out_in))
    else $error("timer output missing from shared pin");

  AST_TOUT_HPE: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    host_port_enable_input_in |=> shared_host_irq_timer_pin_out == $past(host_irq_n_in))
    else $error("timer leaked while host port enabled");

  AST_RD_LEVEL: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    s_rd_sr |=> mmr_rdata_out == {8'h00, $past(host_data_pins_in)})
    else $error("level read does not show pins");

  AST_WR_LEVEL: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    s_wr_lvl ##1 hd_gpio_ok |=> host_data_pins_out == $past(wlo, 2))
    else $error("written level not driven");

  // Sampled reset keeps the release edge out: pads still held at zero there
  AST_SER_OWN: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    reset_n_in |=> ser_pins_oe_out == $past((ser_section_reset_in & ser_gpio_oe_in) |
                                      (~ser_section_reset_in & ser_prim_oe_in)))
    else $error("serial pin ownership wrong");

  AST_CR_READ: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    s_rd_cr |=> mmr_rdata_out == {$past(regs_q.tout_en), 7'h00, $past(regs_q.dir)})
    else $error("control read wrong or reserved bits set");

  AST_HD_PRIM_OUT: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    !hd_gpio_ok |=> host_data_pins_out == $past(hpi_data_out_in))
    else $error("host pin drive not taken from host port");

  AST_WR_DIR: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    s_wr_cr |=> regs_q.dir == $past(wlo) &&
      regs_q.tout_en == $past(mmr_req_in.wdata[hpgio_pkg::HPGIO_TOUT_EN_BIT]))
    else $error("control write not stored");

  AST_IRQ_OE: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    host_port_enable_input_in |=> shared_host_irq_timer_pin_oe_out)
    else $error("shared pin not driven while host port enabled");

  AST_RD_NONE: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    s_rd_none |=> mmr_rdata_out == hpgio_pkg::HPGIO_RDATA_RST)
    else $error("unmapped read not zero");

  AST_SER_OUT: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    reset_n_in |=> ser_pins_out == $past((ser_section_reset_in & ser_gpio_out_in) |
                                         (~ser_section_reset_in & ser_prim_out_in)))
    else $error("serial pin drive ownership wrong");

  AST_RSV_ZERO: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    mmr_rdata_out[14:8] == 7'h00)
    else $error("reserved read bits set");

endmodule // hpgio_top
`default_nettype wire

// ---- hpgio_board_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module hpgio_board_model (
  input  wire logic [7:0] pad_drive_in,
  input  wire logic [7:0] pad_oe_in,
  input  wire logic [7:0] board_val_in,
  output logic      [7:0] pad_level_out
);
  // Board drives only released pins, so a dead oe shows
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pad_level_out[i] = pad_oe_in[i] ? pad_drive_in[i] : board_val_in[i];
    end
  end
endmodule // hpgio_board_model
`default_nettype wire

// ---- hpgio_top_bench.sv ----
`timescale 1ns/100ps
`default_nettype none
module hpgio_top_bench;
  logic                      clk = 1'b0;
  logic                      rst_n = 1'b0;
  hpgio_pkg::hpgio_mmr_req_s req = '0;
  logic                      en = 1'b0;
  logic                      wide = 1'b0;
  logic                      irq_n = 1'b1;
  logic                      tmr = 1'b0;
  logic                      sh_o, sh_oe;
  logic [7:0]                p_in, p_o, p_oe;
  logic [7:0]                h_o = 8'h3C;
  logic [7:0]                h_oe = 8'hF0;
  logic [15:0]               rdata, s_o, s_oe;
  logic [15:0]               sres = 16'h0000;
  logic [15:0]               sp = 16'h1234;
  logic [15:0]               spe = 16'h00FF;
  logic [15:0]               sg = 16'hABCD;
  logic [15:0]               sge = 16'hFF0F;
  int                        miscompares = 0;
  int                        compares = 0;
  always #2.5 clk = ~clk;
  hpgio_top hpgio_top_inst (
    .sys_clk_in(clk), .reset_n_in(rst_n), .mmr_req_in(req), .mmr_rdata_out(rdata),
    .host_port_enable_input_in(en), .host_port_wide_mode_in(wide),
    .host_data_pins_in(p_in), .host_data_pins_out(p_o), .host_data_pins_oe_out(p_oe),
    .hpi_data_out_in(h_o), .hpi_data_oe_in(h_oe), .host_irq_n_in(irq_n),
    .timer_one_out_in(tmr), .shared_host_irq_timer_pin_out(sh_o),
    .shared_host_irq_timer_pin_oe_out(sh_oe), .ser_section_reset_in(sres),
    .ser_prim_out_in(sp), .ser_prim_oe_in(spe), .ser_gpio_out_in(sg),
    .ser_gpio_oe_in(sge), .ser_pins_out(s_o), .ser_pins_oe_out(s_oe)
  );
  hpgio_board_model hpgio_board_model_inst (
    .pad_drive_in(p_o), .pad_oe_in(p_oe), .board_val_in(8'h96), .pad_level_out(p_in)
  );
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge clk);
    req <= '0;
  endtask
  // Read data lands on the edge that takes the strobe
  task automatic rchk(input logic [15:0] a, input logic [15:0] exp, input string what);
    @(posedge clk);
    req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 16'h0000};
    @(posedge clk);
    req <= '0;
    #1;
    chk(rdata, exp, what);
  endtask
  // Pins follow a write one edge after wr returns; two spare
  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic end_sim;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    #20000;
    miscompares++;
    $display("BAD %0t watchdog", $time);
    end_sim();
  end
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rchk(16'h003C, 16'h0000, "ctrl reset");
    rchk(16'h003D, 16'h0096, "pins reset");
    chk({8'h00, p_oe}, 16'h0000, "oe reset");
    $display("test reset done");
    wr(16'h003C, 16'h7FFF);
    rchk(16'h003C, 16'h00FF, "ctrl mask");
    wr(16'h003D, 16'hFFA5);
    settle();
    chk({p_oe, p_o}, 16'hFFA5, "drive");
    rchk(16'h003D, 16'h00A5, "level out");
    rchk(16'h003E, 16'h0000, "unmapped");
    wr(16'h003C, 16'h800F);
    settle();
    rchk(16'h003D, 16'h0095, "mixed dir");
    chk({8'h00, p_oe}, 16'h000F, "dir oe");
    chk({14'h0000, sh_oe, sh_o}, 16'h0002, "timer low");
    $display("test gpio done");
    @(posedge clk);
    tmr <= 1'b1;
    irq_n <= 1'b0;
    settle();
    chk({14'h0000, sh_oe, sh_o}, 16'h0003, "timer high");
    @(posedge clk);
    en <= 1'b1;
    settle();
    chk({14'h0000, sh_oe, sh_o}, 16'h0002, "irq owns");
    chk({p_oe, p_o}, {h_oe, h_o}, "hpi owns");
    @(posedge clk);
    wide <= 1'b1;
    settle();
    chk({p_oe, p_o}, 16'h0FA5, "wide gpio");
    @(posedge clk);
    en <= 1'b0;
    wide <= 1'b0;
    wr(16'h003C, 16'h000F);
    settle();
    chk({15'h0000, sh_oe}, 16'h0000, "timer off");
    $display("test shared done");
    @(posedge clk);
    sres <= 16'h00F0;
    settle();
    chk(s_o, (sg & sres) | (sp & ~sres), "ser out");
    chk(s_oe, (sge & sres) | (spe & ~sres), "ser oe");
    $display("test serial done");
    @(posedge clk);
    rst_n <= 1'b0;
    settle();
    chk({sh_oe, 7'h00, p_oe}, 16'h0000, "pins in reset");
    chk(s_oe, 16'h0000, "ser oe in reset");
    @(posedge clk);
    rst_n <= 1'b1;
    rchk(16'h003C, 16'h0000, "ctrl rereset");
    rchk(16'h003D, 16'h0096, "pins rereset");
    $display("test rereset done");
    end_sim();
  end
endmodule // hpgio_top_bench
`default_nettype wire
